// ### mfc_counter.sv
// multi-function counter: ring count, coincidence pulse, latch capture
//
// Overview of operation
// - one output pulse is given for each finished counting cycle while pulse output runs.
// - without increment mode the cycle lasts (upper minus lower) count clock periods.
// - in increment mode the count steps by the increment, so the cycle lasts (upper minus lower) divided by the increment, rounded up, count clock periods.
// - if the stepping count never lands on the compare value no pulse is produced.
// - the coincidence comparator is true while count is at least value A and below value B, or equals A when A equals B.
// - a rising edge on input 0 starts the pulse output.
// - a rising edge on input 1 is a stop event that halts the pulse output.
// - with preset-on-stop enabled each stop event loads the preset value into the count.
// - pulses shorter than the count clock period may be missed, so the clock must be short enough.
// - the fastest 25 ns count clock suits two-phase counting so no pulse of 25 ns or longer is lost.
// - two-phase x1 detection makes up and down steps that raise and lower the count.
// - the latch event is a selectable edge condition on the latch input.
// - each latch event copies the 32-bit unsigned count into the latch value register.
// - each later latch event overwrites the latch value, the old one is not kept.
// - the latch value sits at address 1000 where the host reads it.
`timescale 1ns/1ps
`include "mfc_defs.svh"
module mfc_counter (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  inLevel,
  input  wire logic        latchIn,
  output logic             pulseOut
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0]      count;
    logic [31:0]      latchVal;
    logic [31:0]      divCnt;
    mfc_pkg::mfc_run_e run;
    logic             pulse;
    logic             cmpPrev;
  } mfc_cnt_s;
  mfc_cnt_s st_q, st_d;

  mfc_pkg::mfc_cfg_s  cfg;
  mfc_pkg::mfc_step_s step;
  logic [31:0] clkDiv;
  logic        tick, startEv, stopEv, latchEv, cmpHit;
  logic [32:0] nextUp;
  logic [31:0] inc;

  mfc_apb_regs u_regs (
    .clk      (clk),
    .reset_n  (reset_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .count    (st_q.count),
    .latchVal (st_q.latchVal),
    .status   ({st_q.pulse, st_q.run == mfc_pkg::MFC_RUN}),
    .cfg      (cfg),
    .clkDiv   (clkDiv)
  );

  // 25 ns sampling when two-phase to avoid missing short pulses
  // >= so that lowering the divider never waits for a 32-bit wrap
  assign tick = cfg.twoPhase || (st_q.divCnt >= clkDiv);

  mfc_edge_detect u_edge (
    .clk      (clk),
    .reset_n  (reset_n),
    .sampleEn (tick),
    .inLevel  (inLevel),
    .latchIn  (latchIn),
    .latchSel (cfg.latchSel),
    .startEv  (startEv),
    .stopEv   (stopEv),
    .latchEv  (latchEv),
    .step     (step)
  );

  ////////////////////////////////////////////////////////////////////////
  assign inc    = cfg.addMode ? cfg.addVal : 32'h0000_0001;
  assign nextUp = {1'b0, st_q.count} + {1'b0, inc};
  // range form; with A equal to B only an exact landing on A qualifies
  assign cmpHit = (cfg.cmpA == cfg.cmpB) ? (st_q.count == cfg.cmpA)
                : (st_q.count >= cfg.cmpA && st_q.count < cfg.cmpB);

  always_comb begin
    st_d         = st_q;
    st_d.pulse   = 1'b0;
    st_d.cmpPrev = cmpHit;
    st_d.divCnt  = tick ? 32'h0000_0000 : st_q.divCnt + 32'h0000_0001;
    if (tick && cfg.countEn) begin
      if (cfg.twoPhase) begin
        if (step.up && !step.down) begin
          st_d.count = (st_q.count == cfg.upper)
                     ? (cfg.ring ? cfg.lower : st_q.count)
                     : st_q.count + 32'h0000_0001;
        end else if (step.down && !step.up) begin
          st_d.count = (st_q.count == cfg.lower)
                     ? (cfg.ring ? cfg.upper : st_q.count)
                     : st_q.count - 32'h0000_0001;
        end
      end else if (nextUp >= {1'b0, cfg.upper}) begin
        st_d.count = cfg.ring ? cfg.lower : cfg.upper;
      end else begin
        st_d.count = nextUp[31:0];
      end
    end
    if (startEv) begin
      st_d.run = mfc_pkg::MFC_RUN;
    end
    if (stopEv) begin
      st_d.run = mfc_pkg::MFC_IDLE;
      if (cfg.stopPreset) begin
        st_d.count = cfg.preset;
      end
    end
    case (st_q.run)
      mfc_pkg::MFC_RUN:
        st_d.pulse = cmpHit & ~st_q.cmpPrev;
      default:
        st_d.pulse = 1'b0;
    endcase
    // newest capture always replaces the old one
    if (latchEv) begin
      st_d.latchVal = st_q.count;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= '0;
      st_q.run <= mfc_pkg::MFC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulseOut = st_q.pulse;
endmodule // mfc_counter

// ### mfc_defs.svh
// constants for the multi-function counter block: offsets, resets, timing
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH
`define MFC_CLK_NS          25
`define MFC_OFF_CTRL        12'h000
`define MFC_OFF_UPPER       12'h004
`define MFC_OFF_LOWER       12'h008
`define MFC_OFF_ADDVAL      12'h00C
`define MFC_OFF_PRESET      12'h010
`define MFC_OFF_CMPA        12'h014
`define MFC_OFF_CMPB        12'h018
`define MFC_OFF_CLKDIV      12'h01C
`define MFC_OFF_COUNT       12'h020
`define MFC_OFF_STATUS      12'h024
`define MFC_OFF_LATCH       12'h3E8
`define MFC_CTRL_COUNT_EN   0
`define MFC_CTRL_RING       1
`define MFC_CTRL_ADD_MODE   2
`define MFC_CTRL_STOP_PRE   3
`define MFC_CTRL_TWO_PHASE  4
`define MFC_CTRL_LAT_SEL    6
`define MFC_CTRL_RESET      32'h0000_0043
`define MFC_UPPER_RESET     32'h0000_03E8
`define MFC_LOWER_RESET     32'h0000_0000
`define MFC_CMP_RESET       32'h0000_03E7
`define MFC_CLKDIV_RESET    32'h0000_0000
`endif

// ### mfc_pkg.sv
// types shared by the multi-function counter block
package mfc_pkg;
  typedef enum logic [1:0] {
    MFC_EDGE_RISE, MFC_EDGE_FALL, MFC_EDGE_BOTH, MFC_EDGE_NONE
  } mfc_edge_e;
  typedef enum {MFC_IDLE, MFC_RUN} mfc_run_e;
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] addVal;
    logic [31:0] preset;
    logic [31:0] cmpA;
    logic [31:0] cmpB;
    logic        countEn;
    logic        ring;
    logic        addMode;
    logic        stopPreset;
    logic        twoPhase;
    mfc_edge_e   latchSel;
  } mfc_cfg_s;
  typedef struct packed {
    logic up;
    logic down;
  } mfc_step_s;
endpackage

// ### mfc_edge_detect.sv
// edge detector for start, stop, latch and two-phase quadrature inputs
`timescale 1ns/1ps
module mfc_edge_detect (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              sampleEn,
  input  wire logic [1:0]        inLevel,
  input  wire logic              latchIn,
  input  wire mfc_pkg::mfc_edge_e latchSel,
  output logic                   startEv,
  output logic                   stopEv,
  output logic                   latchEv,
  output mfc_pkg::mfc_step_s     step
);
  typedef struct packed {
    logic [1:0] inPrev;
    logic       latPrev;
  } mfc_ed_s;
  mfc_ed_s st_q, st_d;
  logic    latRise, latFall;

  always_comb begin
    st_d = st_q;
    if (sampleEn) begin
      st_d.inPrev  = inLevel;
      st_d.latPrev = latchIn;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign startEv = sampleEn & inLevel[0] & ~st_q.inPrev[0];
  assign stopEv  = sampleEn & inLevel[1] & ~st_q.inPrev[1];
  assign latRise = latchIn & ~st_q.latPrev;
  assign latFall = ~latchIn & st_q.latPrev;

  // latch edge condition is selectable
  always_comb begin
    case (latchSel)
      mfc_pkg::MFC_EDGE_RISE: latchEv = sampleEn & latRise;
      mfc_pkg::MFC_EDGE_FALL: latchEv = sampleEn & latFall;
      mfc_pkg::MFC_EDGE_BOTH: latchEv = sampleEn & (latRise | latFall);
      default:                latchEv = 1'b0;
    endcase
  end

  // x1 quadrature: count only on A rising (B low = up) or A falling (B low
  // = down); inputs narrower than one sample period are lost
  always_comb begin
    step.up   = sampleEn & inLevel[0] & ~st_q.inPrev[0] & ~inLevel[1];
    step.down = sampleEn & ~inLevel[0] & st_q.inPrev[0] & ~inLevel[1];
  end
endmodule // mfc_edge_detect

// ### mfc_apb_regs.sv
// apb slave holding the configuration and showing count and latch value
`timescale 1ns/1ps
`include "mfc_defs.svh"
module mfc_apb_regs (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [31:0]   count,
  input  wire logic [31:0]   latchVal,
  input  wire logic [1:0]    status,
  output mfc_pkg::mfc_cfg_s  cfg,
  output logic [31:0]        clkDiv
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] addVal;
    logic [31:0] preset;
    logic [31:0] cmpA;
    logic [31:0] cmpB;
    logic [31:0] clkDiv;
    logic [31:0] rdata;
    logic        err;
  } mfc_rg_s;
  mfc_rg_s st_q, st_d;
  logic    acc;

  function automatic logic known(input logic [11:0] a);
    known = (a <= `MFC_OFF_STATUS && a[1:0] == 2'b00) ||
            a == `MFC_OFF_LATCH;
  endfunction

  assign acc = psel & penable;

  always_comb begin
    st_d = st_q;
    if (psel && !penable) begin
      st_d.err = ~known(paddr);
      case (paddr)
        `MFC_OFF_CTRL:   st_d.rdata = st_q.ctrl;
        `MFC_OFF_UPPER:  st_d.rdata = st_q.upper;
        `MFC_OFF_LOWER:  st_d.rdata = st_q.lower;
        `MFC_OFF_ADDVAL: st_d.rdata = st_q.addVal;
        `MFC_OFF_PRESET: st_d.rdata = st_q.preset;
        `MFC_OFF_CMPA:   st_d.rdata = st_q.cmpA;
        `MFC_OFF_CMPB:   st_d.rdata = st_q.cmpB;
        `MFC_OFF_CLKDIV: st_d.rdata = st_q.clkDiv;
        `MFC_OFF_COUNT:  st_d.rdata = count;
        `MFC_OFF_STATUS: st_d.rdata = {30'h0000_0000, status};
        `MFC_OFF_LATCH:  st_d.rdata = latchVal;
        default:         st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        `MFC_OFF_CTRL:   st_d.ctrl   = {24'h00_0000, pwdata[7:0]};
        `MFC_OFF_UPPER:  st_d.upper  = pwdata;
        `MFC_OFF_LOWER:  st_d.lower  = pwdata;
        `MFC_OFF_ADDVAL: st_d.addVal = pwdata;
        `MFC_OFF_PRESET: st_d.preset = pwdata;
        `MFC_OFF_CMPA:   st_d.cmpA   = pwdata;
        `MFC_OFF_CMPB:   st_d.cmpB   = pwdata;
        `MFC_OFF_CLKDIV: st_d.clkDiv = pwdata;
        default:         st_d.ctrl   = st_q.ctrl;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q        <= '0;
      st_q.ctrl   <= `MFC_CTRL_RESET;
      st_q.upper  <= `MFC_UPPER_RESET;
      st_q.lower  <= `MFC_LOWER_RESET;
      st_q.preset <= `MFC_LOWER_RESET;
      st_q.cmpA   <= `MFC_CMP_RESET;
      st_q.cmpB   <= `MFC_CMP_RESET;
      st_q.clkDiv <= `MFC_CLKDIV_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = st_q.rdata;
  assign pslverr = acc & st_q.err;
  assign clkDiv  = st_q.clkDiv;
  always_comb begin
    cfg            = '0;
    cfg.upper      = st_q.upper;
    cfg.lower      = st_q.lower;
    cfg.addVal     = st_q.addVal;
    cfg.preset     = st_q.preset;
    cfg.cmpA       = st_q.cmpA;
    cfg.cmpB       = st_q.cmpB;
    cfg.countEn    = st_q.ctrl[`MFC_CTRL_COUNT_EN];
    cfg.ring       = st_q.ctrl[`MFC_CTRL_RING];
    cfg.addMode    = st_q.ctrl[`MFC_CTRL_ADD_MODE];
    cfg.stopPreset = st_q.ctrl[`MFC_CTRL_STOP_PRE];
    cfg.twoPhase   = st_q.ctrl[`MFC_CTRL_TWO_PHASE];
    cfg.latchSel   = mfc_pkg::mfc_edge_e'(st_q.ctrl[`MFC_CTRL_LAT_SEL+:2]);
  end
endmodule // mfc_apb_regs

// ### mfc_counter_properties.sv
// assertions on the ports of the multi-function counter
`timescale 1ns/1ps
`include "mfc_defs.svh"
module mfc_counter_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  inLevel,
  input wire logic        latchIn,
  input wire logic        pulseOut
);
  logic startSeen_q;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // a pulse may only follow a start level seen since reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) startSeen_q <= 1'b0;
    else if (inLevel[0]) startSeen_q <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_errPhase; pslverr |-> psel && penable; endproperty
  a_errPhase: assert property (p_errPhase) else $error("stray error");
  property p_errData; pslverr |-> prdata == 32'h0; endproperty
  a_errData: assert property (p_errData) else $error("error data");
  property p_latchMap;
    psel && penable && paddr == `MFC_OFF_LATCH |-> !pslverr;
  endproperty
  a_latchMap: assert property (p_latchMap) else $error("no latch");
  property p_hold; psel && penable ##1 !psel |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_onePulse; pulseOut |=> !pulseOut; endproperty
  a_onePulse: assert property (p_onePulse) else $error("wide pulse");
  property p_start; pulseOut |-> startSeen_q; endproperty
  a_start: assert property (p_start) else $error("pulse unstarted");
  property p_wake; $rose(reset_n) |-> !pulseOut [*2]; endproperty
  a_wake: assert property (p_wake) else $error("pulse at wake");
endmodule // mfc_counter_properties

// ### mfc_terminals.sv
// model of the terminals wired to the counter inputs
`timescale 1ns/1ps
module mfc_terminals (
  input  wire logic       clk,
  output logic      [1:0] inLevel,
  output logic            latchIn
);
  logic [2:0] pins_q = 3'b000;
  assign inLevel = pins_q[1:0];
  assign latchIn = pins_q[2];
  // each level stands h clocks, h kept at least one count tick
  task pulse(input int idx, input int h);
    pins_q[idx] <= 1'b1;
    repeat (h) @(posedge clk);
    pins_q[idx] <= 1'b0;
    repeat (h) @(posedge clk);
  endtask
  task drive(input int idx, input logic v);
    pins_q[idx] <= v;
    @(posedge clk);
  endtask
  // one x1 step: a leads b going up, b leads a going down
  task quad(input logic up, input int h);
    logic [7:0] s;
    s = up ? 8'b00_10_11_01 : 8'b00_01_11_10;
    for (int j = 0; j < 4; j++) begin
      pins_q[1:0] <= s[2*j +: 2];
      repeat (h) @(posedge clk);
    end
  endtask
endmodule // mfc_terminals

// ### mfc_counter_tb.sv
// self-checking bench for the multi-function counter
`timescale 1ns/1ps
`include "mfc_defs.svh"
bind mfc_counter mfc_counter_properties u_props (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .inLevel(inLevel),
  .latchIn(latchIn), .pulseOut(pulseOut));
module mfc_counter_tb;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        pulseOut, latchIn, e;
  logic [1:0]  inLevel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cnt, lat;
  int          n_fail, n_tests, seed, gp, dv, pv, eg, k, n, m;
  int          cf[7];
  int          tu[4] = '{10, 12, 12, 10};
  int          ti[4] = '{1, 3, 5, 1};
  int          ta[4] = '{9, 9, 9, 3};
  int          tb[4] = '{9, 9, 9, 6};

  mfc_counter u_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inLevel(inLevel),
    .latchIn(latchIn), .pulseOut(pulseOut));
  mfc_terminals u_term (.clk(clk), .inLevel(inLevel), .latchIn(latchIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stall();
    n_fail++;
    results();
  endtask
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (j = 0; j < 16; j++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (j == 16) stall();
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rdchk(string s, logic [11:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, e);
    chk(s, x, rd);
  endtask
  // spacing of the last two pulses seen in the window
  task automatic watch(int win, output int g);
    int c = 0;
    int last = 0;
    g = 0;
    for (int t = 0; t < win; t++) begin
      @(posedge clk);
      if (pulseOut === 1'b1) begin
        if (c > 0) g = t - last;
        c++;
        last = t;
      end
    end
  endtask
  function automatic int expGap(int u, int inc, int a, int b, int d);
    int c = 0;
    int t = 0;
    bit hit = 0;
    do begin
      hit |= (a == b) ? c == a : (c >= a && c < b);
      t++;
      c = (c + inc >= u) ? 0 : c + inc;
    end while (c != 0);
    return hit ? t * (d + 1) : 0;
  endfunction

  initial begin
    seed = 80;
    n_fail = 0;
    n_tests = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("ctrl", `MFC_OFF_CTRL, `MFC_CTRL_RESET);
    rdchk("upper", `MFC_OFF_UPPER, `MFC_UPPER_RESET);
    rdchk("cmpa", `MFC_OFF_CMPA, `MFC_CMP_RESET);
    apb(1'b1, 12'h040, 32'hFFFF_FFFF, rd, e);
    chk("unmapped", 32'h1, {31'h0, e});
    for (int i = 0; i < 4; i++) begin
      dv = $random(seed) & 3;
      pv = $random(seed) & 7;
      cf = '{tu[i], 0, ti[i], pv, ta[i], tb[i], dv};
      for (int r = 0; r < 7; r++) wr(12'(4 * r + 4), cf[r]);
      wr(`MFC_OFF_CTRL, ti[i] > 1 ? 32'h0F : 32'h0B);
      u_term.pulse(0, dv + 2);
      watch(300, gp);
      eg = expGap(tu[i], ti[i], ta[i], tb[i], dv);
      chk("gap", eg, gp);
      wr(`MFC_OFF_CLKDIV, 99);
      u_term.drive(1, 1'b1);
      for (k = 0; k < 80; k++) begin
        apb(1'b0, `MFC_OFF_STATUS, 32'h0, rd, e);
        if (rd[0] === 1'b0) break;
      end
      if (k == 80) stall();
      rdchk("preset", `MFC_OFF_COUNT, pv);
      u_term.drive(1, 1'b0);
    end
    wr(`MFC_OFF_CLKDIV, 0);
    wr(`MFC_OFF_UPPER, 20000);
    wr(`MFC_OFF_CTRL, 32'h13);
    apb(1'b0, `MFC_OFF_COUNT, 32'h0, cnt, e);
    n = 8 + ($random(seed) & 7);
    m = $random(seed) & 7;
    repeat (n) u_term.quad(1'b1, 2);
    repeat (m) u_term.quad(1'b0, 2);
    cnt = cnt + n - m;
    rdchk("updown", `MFC_OFF_COUNT, cnt);
    for (int s = 0; s < 4; s++) begin
      wr(`MFC_OFF_CTRL, 32'h13 | 32'(s << 6));
      u_term.quad(1'b1, 2);
      cnt = cnt + 32'h1;
      if (s != 3) lat = cnt;
      u_term.pulse(2, 2);
      rdchk("latch", `MFC_OFF_LATCH, lat);
    end
    // linear mode parks at the upper limit instead of wrapping
    wr(`MFC_OFF_UPPER, 32'h0000_0040);
    wr(`MFC_OFF_CTRL, 32'h0000_0001);
    repeat (80) @(posedge clk);
    rdchk("linear", `MFC_OFF_COUNT, 32'h0000_0040);
    results();
  end
endmodule // mfc_counter_tb
